// ### pkg/rptac_pkg.sv
// constants and types shared by the rate-pin tracker and active-control mirror
package rptac_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RATE_PIN_TRACK = 8'h20;
    localparam logic [7:0] ADDR_ACTIVE_CTRL = 8'h21;

    // ------------------------------------------------------------
    // rate_pin_track_ctrl field positions
    // ------------------------------------------------------------
    localparam int TRK_LEVEL_BIT = 7;
    localparam int TRK_RISE_SEEN_BIT = 6;
    localparam int TRK_FALL_SEEN_BIT = 5;
    localparam int TRK_FULL_RISE_BIT = 4;
    localparam int TRK_KEEP_RISE_BIT = 3;
    localparam int TRK_FULL_FALL_BIT = 2;
    localparam int TRK_KEEP_FALL_BIT = 1;
    localparam logic [3:0] TRK_EN_RESET = 4'h0;

    // ------------------------------------------------------------
    // active_control_mirror field positions and reset values
    // ------------------------------------------------------------
    localparam int CTL_MODE_LSB = 12;
    localparam int CTL_PIN2_LSB = 10;
    localparam int CTL_PIN1_LSB = 8;
    localparam int CTL_CHOFF_LSB = 4;
    localparam logic [3:0] CTL_MODE_RESET = 4'h0;
    localparam logic [1:0] CTL_PIN2_RESET = 2'h1;
    localparam logic [1:0] CTL_PIN1_RESET = 2'h3;
    localparam logic [15:0] CTL_RESET_4CH = 16'h0700;

    // ------------------------------------------------------------
    // sample-mode codes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_ADAPT_1024 = 4'h0;
    localparam logic [3:0] MODE_ADAPT_8 = 4'h3;
    localparam logic [3:0] MODE_PLAIN_1024 = 4'h4;
    localparam logic [3:0] MODE_PLAIN_8 = 4'h7;
    localparam logic [3:0] MODE_SINGLE = 4'h8;
    localparam logic [3:0] MODE_SINGLE_X8 = 4'h9;
    localparam logic [3:0] MODE_FAST = 4'hA;
    localparam logic [3:0] MODE_BURST = 4'hB;
    localparam logic [3:0] MODE_SLEEP = 4'hF;

    // rate index: 0=1024, 1=256, 2=64, 3=8 samples per second
    localparam logic [1:0] RATE_IDX_8SPS = 2'h3;

    // ------------------------------------------------------------
    // dual-function pin selects
    // ------------------------------------------------------------
    localparam logic [1:0] PIN_ALERT = 2'h0;
    localparam logic [1:0] PIN_GP_IN = 2'h1;
    localparam logic [1:0] PIN_GP_OUT = 2'h2;
    localparam logic [1:0] PIN_RATE_IN = 2'h3;

    // conversion timing class
    typedef enum logic [2:0] {
        RPTAC_CONV_ADAPT,
        RPTAC_CONV_PLAIN,
        RPTAC_CONV_SINGLE,
        RPTAC_CONV_SINGLE_X8,
        RPTAC_CONV_FAST,
        RPTAC_CONV_BURST,
        RPTAC_CONV_RESERVED,
        RPTAC_CONV_SLEEP
    } rptac_conv_type;

endpackage

// ### pkg/rptac_pin_if.sv
// synchronised rate-reduce pin level and edge pulses between modules
interface rptac_pin_if;
    logic level;
    logic rise;
    logic fall;

    modport src (
        output level,
        output rise,
        output fall
    );
    modport dst (
        input level,
        input rise,
        input fall
    );
endinterface

// ### core/rptac_pin_sync.sv
// two-stage synchroniser and edge detector for the rate-reduce pin
module rptac_pin_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // asynchronous pin
    input wire logic rate_pin_i,
    // synchronised result
    rptac_pin_if.src pin
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        logic [2:0] primed;
        logic rise;
        logic fall;
    } rptac_sync_type;

    rptac_sync_type st_r;
    rptac_sync_type st_nxt;

    // meta feeds only sync; edges come from sync against last
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = rate_pin_i;
        st_nxt.sync = st_r.meta;
        st_nxt.last = st_r.sync;
        st_nxt.primed = {st_r.primed[1:0], 1'b1};
        // three samples fill meta, sync and last with the real pin, so a pin
        // already high at reset release does not count as a rising edge
        st_nxt.rise = st_r.primed[2] & st_r.sync & ~st_r.last;
        st_nxt.fall = st_r.primed[2] & ~st_r.sync & st_r.last;
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign pin.level = st_r.last;
    assign pin.rise = st_r.rise & ce_i;
    assign pin.fall = st_r.fall & ce_i;

endmodule

// ### core/rptac_mode_decode.sv
// decode of the active control settings into conversion controls
module rptac_mode_decode (
    // active settings
    input wire logic [15:0] active_ctrl_i,
    input wire logic rate_pin_level_i,
    input wire logic no_skip_i,
    // decoded controls
    output rptac_pkg::rptac_conv_type conv_type_o,
    output logic [1:0] rate_idx_o,
    output logic [1:0] pin1_function_sel_o,
    output logic [1:0] pin2_function_sel_o,
    output logic rate_override_o,
    output logic [3:0] chan_active_o,
    output logic [3:0] ptr_skip_o
);

    logic [3:0] mode;
    logic [3:0] off;

    assign mode = active_ctrl_i[rptac_pkg::CTL_MODE_LSB +: 4];
    assign off = active_ctrl_i[rptac_pkg::CTL_CHOFF_LSB +: 4];
    assign pin1_function_sel_o = active_ctrl_i[rptac_pkg::CTL_PIN1_LSB +: 2];
    assign pin2_function_sel_o = active_ctrl_i[rptac_pkg::CTL_PIN2_LSB +: 2];

    // a high rate-reduce pin on either pin forces 8 samples per second in the adapt and plain modes
    assign rate_override_o = rate_pin_level_i &
        ((pin1_function_sel_o == rptac_pkg::PIN_RATE_IN) |
         (pin2_function_sel_o == rptac_pkg::PIN_RATE_IN));

    // disabled channels leave the round robin and single-shot sequence, except while no_skip_i is set
    assign chan_active_o = ~off;
    assign ptr_skip_o = no_skip_i ? 4'h0 : off;

    // sample-mode classification
    always_comb begin
        rate_idx_o = mode[1:0];
        if (mode <= rptac_pkg::MODE_ADAPT_8) begin
            conv_type_o = rptac_pkg::RPTAC_CONV_ADAPT;
        end else if (mode <= rptac_pkg::MODE_PLAIN_8) begin
            conv_type_o = rptac_pkg::RPTAC_CONV_PLAIN;
        end else if (mode == rptac_pkg::MODE_SINGLE) begin
            conv_type_o = rptac_pkg::RPTAC_CONV_SINGLE;
        end else if (mode == rptac_pkg::MODE_SINGLE_X8) begin
            conv_type_o = rptac_pkg::RPTAC_CONV_SINGLE_X8;
        end else if (mode == rptac_pkg::MODE_FAST) begin
            conv_type_o = rptac_pkg::RPTAC_CONV_FAST;
        end else if (mode == rptac_pkg::MODE_BURST) begin
            conv_type_o = rptac_pkg::RPTAC_CONV_BURST;
        end else if (mode == rptac_pkg::MODE_SLEEP) begin
            conv_type_o = rptac_pkg::RPTAC_CONV_SLEEP;
        end else begin
            conv_type_o = rptac_pkg::RPTAC_CONV_RESERVED;
        end
        // the override only slows free-running rate modes
        if (rate_override_o && (conv_type_o == rptac_pkg::RPTAC_CONV_ADAPT ||
                                conv_type_o == rptac_pkg::RPTAC_CONV_PLAIN)) begin
            rate_idx_o = rptac_pkg::RATE_IDX_8SPS;
        end
    end

endmodule

// ### core/rptac_top.sv
// rate-reduce pin tracker and active control mirror register pair
module rptac_top #(
    parameter int CHANNELS = 4
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // asynchronous rate-reduce pin
    input wire logic rate_pin_i,
    // register access from the command decoder
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // host snapshot commands, one-cycle pulses
    input wire logic host_snap_full_i,
    input wire logic host_snap_general_i,
    input wire logic host_snap_keep_i,
    // pending control settings and conversion status
    input wire logic [15:0] ctrl_pending_i,
    input wire logic conv_cycle_end_i,
    input wire logic no_skip_i,
    // actions to the measurement datapath
    output logic results_load_o,
    output logic accum_clear_o,
    output logic images_latch_o,
    output logic settings_activate_o,
    output logic limited_full_o,
    output logic limited_keep_o,
    // decoded active settings
    output rptac_pkg::rptac_conv_type conv_type_o,
    output logic [1:0] rate_idx_o,
    output logic [1:0] pin1_function_sel_o,
    output logic [1:0] pin2_function_sel_o,
    output logic rate_override_o,
    output logic [3:0] chan_active_o,
    output logic [3:0] ptr_skip_o,
    output logic mode_change_pending_o
);

    // ------------------------------------------------------------
    // elaboration check and variant reset value
    // ------------------------------------------------------------
    if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
        $error("CHANNELS must be between 1 and 4");
    end

    // unused upper channels come out of reset switched off
    localparam logic [3:0] CHOFF_RESET = 4'(((1 << (4 - CHANNELS)) - 1));
    localparam logic [15:0] CTL_RESET = rptac_pkg::CTL_RESET_4CH |
        {8'h00, CHOFF_RESET, 4'h0};

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic rise_seen;
        logic fall_seen;
        logic [3:0] edge_en;          // full rise, keep rise, full fall, keep fall
        logic [15:0] active_ctrl;
        logic [3:0] staged_mode;
        logic mode_wait;
        logic [15:0] rdata;
        logic results_load;
        logic accum_clear;
        logic images_latch;
        logic activate;
        logic lim_full;
        logic lim_keep;
    } rptac_state_type;

    rptac_state_type st_r;
    rptac_state_type st_nxt;

    rptac_pin_if pin_sig ();

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    rptac_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .rate_pin_i(rate_pin_i),
        .pin(pin_sig.src)
    );

    // ------------------------------------------------------------
    // edge snapshot selection
    // ------------------------------------------------------------
    logic full_on_edge;
    logic keep_on_edge;
    logic host_full;
    logic host_any;
    logic trk_write;
    logic [7:0] trk_view;

    // the full variant takes priority when both are enabled for one edge
    assign full_on_edge = (pin_sig.rise & st_r.edge_en[3]) |
                          (pin_sig.fall & st_r.edge_en[1]);
    assign keep_on_edge = ~full_on_edge &
                          ((pin_sig.rise & st_r.edge_en[2]) |
                           (pin_sig.fall & st_r.edge_en[0]));
    assign host_full = host_snap_full_i | host_snap_general_i;
    assign host_any = host_full | host_snap_keep_i;
    assign trk_write = reg_wr_i & (reg_addr_i == rptac_pkg::ADDR_RATE_PIN_TRACK);

    // live view of the tracker register
    always_comb begin
        trk_view = 8'h00;
        trk_view[rptac_pkg::TRK_LEVEL_BIT] = pin_sig.level;
        trk_view[rptac_pkg::TRK_RISE_SEEN_BIT] = st_r.rise_seen;
        trk_view[rptac_pkg::TRK_FALL_SEEN_BIT] = st_r.fall_seen;
        trk_view[rptac_pkg::TRK_FULL_RISE_BIT] = st_r.edge_en[3];
        trk_view[rptac_pkg::TRK_KEEP_RISE_BIT] = st_r.edge_en[2];
        trk_view[rptac_pkg::TRK_FULL_FALL_BIT] = st_r.edge_en[1];
        trk_view[rptac_pkg::TRK_KEEP_FALL_BIT] = st_r.edge_en[0];
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // sticky edge flags: a full host snapshot clears, a new edge
        // in the same cycle sets again so no transition is lost
        if (host_full) begin
            st_nxt.rise_seen = 1'b0;
            st_nxt.fall_seen = 1'b0;
        end
        if (pin_sig.rise) begin
            st_nxt.rise_seen = 1'b1;
        end
        if (pin_sig.fall) begin
            st_nxt.fall_seen = 1'b1;
        end

        // enables change only by a write and take effect at once
        if (trk_write) begin
            st_nxt.edge_en = {reg_wdata_i[rptac_pkg::TRK_FULL_RISE_BIT],
                              reg_wdata_i[rptac_pkg::TRK_KEEP_RISE_BIT],
                              reg_wdata_i[rptac_pkg::TRK_FULL_FALL_BIT],
                              reg_wdata_i[rptac_pkg::TRK_KEEP_FALL_BIT]};
        end

        // action pulses to the datapath
        st_nxt.lim_full = full_on_edge;
        st_nxt.lim_keep = keep_on_edge;
        st_nxt.results_load = host_any | full_on_edge | keep_on_edge;
        // the keep variants never touch the running accumulators
        st_nxt.accum_clear = host_full | full_on_edge;
        // images and activation follow host commands only
        st_nxt.images_latch = host_any;
        st_nxt.activate = host_any;

        // activation of pending settings into the mirror
        if (host_any) begin
            st_nxt.active_ctrl[11:4] = ctrl_pending_i[11:4];
            if (ctrl_pending_i[15:12] != st_r.active_ctrl[15:12]) begin
                // a new sample mode waits for the running cycle to end
                st_nxt.staged_mode = ctrl_pending_i[15:12];
                st_nxt.mode_wait = 1'b1;
            end else begin
                st_nxt.mode_wait = 1'b0;
            end
        end else if (st_r.mode_wait && conv_cycle_end_i) begin
            st_nxt.active_ctrl[15:12] = st_r.staged_mode;
            st_nxt.mode_wait = 1'b0;
        end

        // registered read data, unmapped addresses read as zero
        if (reg_addr_i == rptac_pkg::ADDR_RATE_PIN_TRACK) begin
            st_nxt.rdata = {8'h00, trk_view};
        end else if (reg_addr_i == rptac_pkg::ADDR_ACTIVE_CTRL) begin
            st_nxt.rdata = {st_r.active_ctrl[15:4], 4'h0};
        end else begin
            st_nxt.rdata = 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.edge_en <= rptac_pkg::TRK_EN_RESET;
            st_r.active_ctrl <= CTL_RESET;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // decode of settings in force
    // ------------------------------------------------------------
    rptac_mode_decode u_decode (
        .active_ctrl_i(st_r.active_ctrl),
        .rate_pin_level_i(pin_sig.level),
        .no_skip_i(no_skip_i),
        .conv_type_o(conv_type_o),
        .rate_idx_o(rate_idx_o),
        .pin1_function_sel_o(pin1_function_sel_o),
        .pin2_function_sel_o(pin2_function_sel_o),
        .rate_override_o(rate_override_o),
        .chan_active_o(chan_active_o),
        .ptr_skip_o(ptr_skip_o)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = st_r.rdata;
    assign results_load_o = st_r.results_load;
    assign accum_clear_o = st_r.accum_clear;
    assign images_latch_o = st_r.images_latch;
    assign settings_activate_o = st_r.activate;
    assign limited_full_o = st_r.lim_full;
    assign limited_keep_o = st_r.lim_keep;
    assign mode_change_pending_o = st_r.mode_wait;

endmodule

// ### verification/rptac_assertions.sv
// concurrent checks on the rate-pin tracker and active-control mirror ports
module rptac_assertions #(
    parameter int CHANNELS = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // inputs of the block
    input wire logic rate_pin_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic host_snap_full_i,
    input wire logic host_snap_general_i,
    input wire logic host_snap_keep_i,
    input wire logic no_skip_i,
    // outputs of the block
    input wire logic [15:0] reg_rdata_o,
    input wire logic results_load_o,
    input wire logic accum_clear_o,
    input wire logic images_latch_o,
    input wire logic settings_activate_o,
    input wire logic limited_full_o,
    input wire logic limited_keep_o,
    input wire logic [1:0] pin1_function_sel_o,
    input wire logic [1:0] pin2_function_sel_o,
    input wire logic rate_override_o,
    input wire logic [3:0] chan_active_o,
    input wire logic [3:0] ptr_skip_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // snapshot actions
    // ------------------------------------------------------------
    images_host_only_a: assert property (
        images_latch_o |-> $past(host_snap_full_i || host_snap_general_i || host_snap_keep_i))
        else $error("prior images latched without a host snapshot");
    activate_host_only_a: assert property (
        settings_activate_o |-> $past(host_snap_full_i || host_snap_general_i || host_snap_keep_i))
        else $error("settings activated without a host snapshot");
    one_limited_kind_a: assert property (!(limited_full_o && limited_keep_o))
        else $error("both limited snapshot kinds fired together");
    limited_loads_a: assert property ((limited_full_o || limited_keep_o) |-> results_load_o)
        else $error("limited snapshot without result refresh");
    full_clears_a: assert property (limited_full_o |-> accum_clear_o)
        else $error("limited full snapshot did not clear accumulators");
    keep_spares_accum_a: assert property (
        limited_keep_o && !$past(host_snap_full_i || host_snap_general_i) |-> !accum_clear_o)
        else $error("limited keep snapshot cleared accumulators");
    // a limited pulse needs a pin change a few cycles before: glitch-free edge path
    edge_caused_a: assert property (
        $rose(limited_full_o || limited_keep_o) |-> $past(rate_pin_i, 1) != $past(rate_pin_i, 7))
        else $error("limited snapshot without a pin transition");
    // ------------------------------------------------------------
    // register reads and decoded settings
    // ------------------------------------------------------------
    unmapped_zero_a: assert property (
        !($past(reg_addr_i) inside {8'h20, 8'h21}) |-> reg_rdata_o == 16'h0000)
        else $error("unmapped address read non-zero");
    tracker_layout_a: assert property (
        $past(reg_addr_i) == 8'h20 |-> reg_rdata_o[15:8] == 8'h00 && !reg_rdata_o[0])
        else $error("tracker read has bits outside its field set");
    override_needs_pin_a: assert property (
        rate_override_o |-> pin1_function_sel_o == 2'h3 || pin2_function_sel_o == 2'h3)
        else $error("rate override with no pin in rate-reduce role");
    skip_follows_off_a: assert property (
        ptr_skip_o == (no_skip_i ? 4'h0 : ~chan_active_o))
        else $error("pointer skip mask disagrees with channel enables");
endmodule

bind rptac_top rptac_assertions #(.CHANNELS(CHANNELS)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .rate_pin_i(rate_pin_i), .reg_addr_i(reg_addr_i), .host_snap_full_i(host_snap_full_i),
    .host_snap_general_i(host_snap_general_i), .host_snap_keep_i(host_snap_keep_i), .no_skip_i(no_skip_i),
    .reg_rdata_o(reg_rdata_o), .results_load_o(results_load_o), .accum_clear_o(accum_clear_o),
    .images_latch_o(images_latch_o), .settings_activate_o(settings_activate_o),
    .limited_full_o(limited_full_o), .limited_keep_o(limited_keep_o),
    .pin1_function_sel_o(pin1_function_sel_o), .pin2_function_sel_o(pin2_function_sel_o),
    .rate_override_o(rate_override_o), .chan_active_o(chan_active_o), .ptr_skip_o(ptr_skip_o));

// ### verification/rptac_host_model.sv
// host-side model issuing register accesses and snapshot commands
module rptac_host_model #(
    parameter int SETTLE_CYCLES = 4
) (
    // clock
    input wire logic clk_i,
    // read data back from the block
    input wire logic [15:0] rdata_i,
    // register port and command pulses
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [15:0] wdata_o,
    output logic [2:0] snap_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 16'h0000;
        snap_o = 3'h0;
    end
    // enables are only changed by an explicit rewrite
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i) #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i) #1;
        wr_o = 1'b0;
    endtask
    // read data is registered, so it is taken one edge after the address
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i) #1;
        addr_o = a;
        @(posedge clk_i) #1;
        d = rdata_i;
    endtask
    // one-hot pulse: bit 0 full, bit 1 general call, bit 2 keep-accumulator
    task automatic snap(input logic [2:0] kind);
        @(posedge clk_i) #1;
        snap_o = kind;
        @(posedge clk_i) #1;
        snap_o = 3'h0;
        // scaled stand-in for the wait before results and mirror are read
        repeat (SETTLE_CYCLES) @(posedge clk_i);
    endtask
endmodule

// ### verification/rptac_top_bench.sv
// self-checking bench for the rate-pin tracker and active-control mirror
module rptac_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rate_pin_i = 1'b0;
    logic [15:0] ctrl_pending = 16'h4e50;
    logic conv_end = 1'b0;
    logic no_skip = 1'b0;
    logic [7:0] addr;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [2:0] snap;
    logic [15:0] d;
    logic res_load, acc_clr, img_latch, set_act, lim_full, lim_keep, ovr, mc_pend;
    rptac_pkg::rptac_conv_type conv_type;
    logic [1:0] rate_idx, pin1_sel, pin2_sel;
    logic [3:0] ch_act, ptr_skip;
    int n_fail = 0;
    int total_checks = 0;
    // ------------------------------------------------------------
    // clock, reset, block and host
    // ------------------------------------------------------------
    always #2 clk_i = ~clk_i;
    rptac_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .rate_pin_i(rate_pin_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .host_snap_full_i(snap[0]), .host_snap_general_i(snap[1]), .host_snap_keep_i(snap[2]),
        .ctrl_pending_i(ctrl_pending), .conv_cycle_end_i(conv_end), .no_skip_i(no_skip),
        .results_load_o(res_load), .accum_clear_o(acc_clr), .images_latch_o(img_latch),
        .settings_activate_o(set_act), .limited_full_o(lim_full), .limited_keep_o(lim_keep),
        .conv_type_o(conv_type), .rate_idx_o(rate_idx), .pin1_function_sel_o(pin1_sel),
        .pin2_function_sel_o(pin2_sel), .rate_override_o(ovr), .chan_active_o(ch_act),
        .ptr_skip_o(ptr_skip), .mode_change_pending_o(mc_pend));
    rptac_host_model host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
        .snap_o(snap));
    // ------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp, input string msg);
        total_checks++;
        if (got != exp) begin
            n_fail++;
            $display("ERROR t=%0t %s count %0d expected %0d", $time, msg, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cycle_end();
        @(posedge clk_i) #1;
        conv_end = 1'b1;
        @(posedge clk_i) #1;
        conv_end = 1'b0;
    endtask
    // move the pin, then count every action pulse over the following cycles
    task automatic pin_edge(input logic lvl, input int ef, input int ek);
        int nf, nk, nc, nl, ni;
        nf = 0; nk = 0; nc = 0; nl = 0; ni = 0;
        @(posedge clk_i) #1;
        rate_pin_i = lvl;
        repeat (10) begin
            @(posedge clk_i) #1;
            nf += int'(lim_full === 1'b1);
            nk += int'(lim_keep === 1'b1);
            nc += int'(acc_clr === 1'b1);
            nl += int'(res_load === 1'b1);
            ni += int'(img_latch === 1'b1 || set_act === 1'b1);
        end
        chk_n(nf, ef, "limited full");
        chk_n(nk, ek, "limited keep");
        chk_n(nc, ef, "accumulator clear");
        chk_n(nl, ef + ek, "result refresh");
        chk_n(ni, 0, "image latch or activation");
    endtask
    function automatic rptac_pkg::rptac_conv_type cls(input logic [3:0] c);
        if (c < 4'h4) return rptac_pkg::RPTAC_CONV_ADAPT;
        if (c < 4'h8) return rptac_pkg::RPTAC_CONV_PLAIN;
        case (c)
            4'h8: return rptac_pkg::RPTAC_CONV_SINGLE;
            4'h9: return rptac_pkg::RPTAC_CONV_SINGLE_X8;
            4'ha: return rptac_pkg::RPTAC_CONV_FAST;
            4'hb: return rptac_pkg::RPTAC_CONV_BURST;
            4'hf: return rptac_pkg::RPTAC_CONV_SLEEP;
            default: return rptac_pkg::RPTAC_CONV_RESERVED;
        endcase
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        host.rd(8'h20, d); chk16(d, 16'h0000, "tracker reset");
        host.rd(8'h21, d); chk16(d, 16'h0700, "mirror reset");
        host.wr(8'h20, 16'h00ff); host.rd(8'h20, d); chk16(d, 16'h001e, "writable enables only");
        host.wr(8'h21, 16'hffff); host.rd(8'h21, d); chk16(d, 16'h0700, "mirror is read-only");
        host.rd(8'h33, d); chk16(d, 16'h0000, "unmapped read");
        $display("test regs done");
    endtask
    task automatic t_edges();
        host.wr(8'h20, 16'h0018);
        pin_edge(1'b1, 1, 0);
        host.rd(8'h20, d); chk16(d, 16'h00d8, "level and rise flag");
        chk16({13'h0, ovr, rate_idx}, 16'h0007, "override and forced slowest rate");
        pin_edge(1'b0, 0, 0);
        host.rd(8'h20, d); chk16(d, 16'h0078, "fall flag");
        host.rd(8'h21, d); chk16(d, 16'h0700, "pending kept pending");
        host.wr(8'h20, 16'h0002);
        pin_edge(1'b1, 0, 0);
        pin_edge(1'b0, 0, 1);
        host.wr(8'h20, 16'h0006);
        pin_edge(1'b1, 0, 0);
        pin_edge(1'b0, 1, 0);
        host.snap(3'h2); host.rd(8'h20, d); chk16(d, 16'h0006, "flags cleared by general call");
        $display("test edges done");
    endtask
    task automatic t_mirror();
        host.rd(8'h21, d); chk16(d, 16'h0e50, "mode waits for cycle end");
        chk16({15'h0, mc_pend}, 16'h0001, "mode change pending");
        cycle_end(); host.rd(8'h21, d); chk16(d, 16'h4e50, "mirror settings in force");
        chk16({12'h0, pin2_sel, pin1_sel}, 16'h000e, "pin function selects");
        chk16({8'h0, ch_act, ptr_skip}, 16'h00a5, "channel enables and skip");
        no_skip = 1'b1; #1 chk16({12'h0, ptr_skip}, 16'h0000, "no-skip set");
        no_skip = 1'b0;
        for (int c = 0; c < 16; c++) begin
            ctrl_pending = {4'(c), 12'h700};
            host.snap(c[0] ? 3'h4 : 3'h1);
            cycle_end();
            @(posedge clk_i) #1;
            chk16({13'h0, conv_type}, {13'h0, cls(4'(c))}, "mode class");
        end
        $display("test mirror done");
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        t_regs();
        t_edges();
        t_mirror();
        stop_test();
    end
    // hang guard: the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        $display("ERROR t=%0t watchdog expired", $time);
        stop_test();
    end
endmodule
